// [logic/bus_shadow_mem.v]
// Shadow data and slot target-address word store of the update sequencer
`timescale 1ns/1ns
`default_nettype none
module bus_shadow_mem #(
  parameter AW = 9,
  parameter DW = 16
) (
  input wire i_clk_sys,
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [DW-1:0] i_wdata,
  input wire [AW-1:0] i_raddr,
  output reg [DW-1:0] o_rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  always @(posedge i_clk_sys)
  begin
    if (i_we)
      mem[i_waddr] <= i_wdata;
    o_rdata <= mem[i_raddr];
  end
endmodule
`default_nettype wire

// [logic/bus_update_seq.v]
// Buffered update sequencer: shadow queue, commit modes and UPDATE phase timing
`timescale 1ns/1ns
`default_nettype none
`include "bus_update_map.vh"
module bus_update_seq #(
  parameter AW = `BUS_ADDR_W,
  parameter DW = `BUS_DATA_W,
  parameter CH = 8
) (
  input wire i_clk_sys,
  input wire i_reset,
  input wire i_initiated,
  input wire i_scan_trigger,
  input wire i_write_req,
  input wire [AW-1:0] i_write_addr,
  input wire [DW-1:0] i_write_data,
  input wire i_query_req,
  input wire [AW-1:0] i_query_addr,
  input wire i_commit_now_request,
  input wire i_commit_on_input_change,
  input wire [2:0] i_input_select,
  input wire [CH-1:0] i_digital_in,
  input wire i_window_write,
  input wire [9:0] i_update_window_count,
  output reg o_write_ack,
  output reg o_overflow_error,
  output reg o_window_refused,
  output reg o_busy,
  output reg o_query_valid,
  output reg [DW-1:0] o_query_data,
  output reg o_live_we,
  output reg [AW-1:0] o_live_addr,
  output reg [DW-1:0] o_live_data,
  output reg o_commit_done,
  output reg o_phase_input,
  output reg o_phase_update,
  output reg [9:0] o_window
);
  // ************************************************************
  // Scan phase states and slot length
  // ************************************************************
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_INPUT = 4'h2;
  localparam [3:0] ST_UPDATE = 4'h4;
  localparam [3:0] ST_CALC = 4'h8;
  localparam [19:0] SLOT_CYC = `BUS_SLOT_CYCLES;

  function sel_bit;
    input [CH-1:0] bits;
    input [2:0] sel;
    begin
      sel_bit = bits[sel];
    end
  endfunction

  reg [3:0] phase;
  reg [3:0] next_phase;
  reg [19:0] phase_cnt;
  reg [19:0] upd_len;
  reg [9:0] q_count;
  reg [9:0] q_rd;
  reg imm_pending;
  reg chan_pending;
  reg chan_deferred;
  reg chan_ref;
  reg committing;
  reg [1:0] rd_pipe;
  reg query_held;
  reg [AW-1:0] query_addr;
  reg q_wr_en;
  wire [AW-1:0] addr_rdata;
  wire [DW-1:0] mem_rdata;
  wire [AW-1:0] mem_raddr;
  wire mem_we;
  wire commit_req_any;
  wire accept_window;
  wire chan_now;
  wire update_start;
  wire change_ok;
  wire take_write;

  // ************************************************************
  // Shadow data store
  // ************************************************************
  // Queue slot index addresses data; slot address kept alongside
  assign mem_we = take_write;
  assign mem_raddr = committing ? q_rd[AW-1:0] : query_addr;

  bus_shadow_mem #(
    .AW(AW),
    .DW(DW)
  ) u_mem (
    .i_clk_sys(i_clk_sys),
    .i_we(mem_we),
    .i_waddr(q_count[AW-1:0]),
    .i_wdata(i_write_data),
    .i_raddr(mem_raddr),
    .o_rdata(mem_rdata)
  );

  // Target address of each queue slot, read in step with its data
  bus_shadow_mem #(
    .AW(AW),
    .DW(AW)
  ) u_addr (
    .i_clk_sys(i_clk_sys),
    .i_we(mem_we),
    .i_waddr(q_count[AW-1:0]),
    .i_wdata(i_write_addr),
    .i_raddr(mem_raddr),
    .o_rdata(addr_rdata)
  );

  // ************************************************************
  // Acceptance of changes
  // ************************************************************
  assign commit_req_any = imm_pending | chan_pending | chan_deferred | committing;
  assign chan_now = sel_bit(i_digital_in, i_input_select);
  assign update_start = (phase == ST_INPUT) && (phase_cnt == 20'h00001);
  // Changes stall while a commit is pending; host must retry
  assign change_ok = !commit_req_any &&
    (!i_initiated || phase == ST_INPUT || phase == ST_UPDATE);
  assign take_write = i_write_req && change_ok && (q_count < o_window);
  assign accept_window = i_window_write && !i_initiated &&
    (i_update_window_count >= `BUS_WINDOW_MIN) &&
    (i_update_window_count <= `BUS_WINDOW_MAX);

  always @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_window <= `BUS_WINDOW_RESET;
      o_window_refused <= 1'b0;
      o_write_ack <= 1'b0;
      o_overflow_error <= 1'b0;
    end
    else
    begin
      if (accept_window)
        o_window <= i_update_window_count;
      o_window_refused <= i_window_write && !accept_window;
      o_write_ack <= take_write;
      o_overflow_error <= i_write_req && change_ok && (q_count >= o_window);
    end
  end

  // ************************************************************
  // Scan phase sequencing
  // ************************************************************
  // UPDATE slot length fixed per window, so loop timing never varies
  always @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
      upd_len <= 20'h00000;
    else
      upd_len <= SLOT_CYC * {10'h000, o_window};
  end

  always @*
  begin
    next_phase = phase;
    case (phase)
      ST_IDLE:
        if (i_initiated && i_scan_trigger)
          next_phase = ST_INPUT;
      ST_INPUT:
        if (phase_cnt == 20'h00001)
          next_phase = ST_UPDATE;
      ST_UPDATE:
        if (phase_cnt == 20'h00001)
          next_phase = ST_CALC;
      ST_CALC:
        if (!i_initiated)
          next_phase = ST_IDLE;
        else if (i_scan_trigger)
          next_phase = ST_INPUT;
      default:
        next_phase = ST_IDLE;
    endcase
  end

  always @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      phase <= ST_IDLE;
      phase_cnt <= 20'h00000;
      o_phase_input <= 1'b0;
      o_phase_update <= 1'b0;
    end
    else
    begin
      phase <= next_phase;
      if (next_phase != phase)
        phase_cnt <= (next_phase == ST_INPUT) ? SLOT_CYC :
          (next_phase == ST_UPDATE) ? upd_len : 20'h00000;
      else if (phase_cnt != 20'h00000)
        phase_cnt <= phase_cnt - 20'h00001;
      o_phase_input <= (next_phase == ST_INPUT);
      o_phase_update <= (next_phase == ST_UPDATE);
    end
  end

  // ************************************************************
  // Commit requests and input-change trigger
  // ************************************************************
  always @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      imm_pending <= 1'b0;
      chan_pending <= 1'b0;
      chan_deferred <= 1'b0;
      chan_ref <= 1'b0;
      committing <= 1'b0;
      q_rd <= 10'h000;
      q_count <= 10'h000;
      rd_pipe <= 2'b00;
      o_live_we <= 1'b0;
      o_live_addr <= {AW{1'b0}};
      o_live_data <= {DW{1'b0}};
      o_commit_done <= 1'b0;
    end
    else
    begin
      o_commit_done <= 1'b0;
      o_live_we <= 1'b0;
      if (take_write)
        q_count <= q_count + 10'h001;
      if (i_commit_now_request && !commit_req_any)
        imm_pending <= 1'b1;
      if (i_commit_on_input_change && !commit_req_any)
      begin
        if (i_initiated && phase == ST_UPDATE)
          chan_deferred <= 1'b1;
        else
        begin
          chan_pending <= 1'b1;
          chan_ref <= chan_now;
        end
      end
      if (chan_deferred && next_phase == ST_INPUT && phase != ST_INPUT)
      begin
        chan_deferred <= 1'b0;
        chan_pending <= 1'b1;
        chan_ref <= chan_now;
      end
      // Not initiated: no scan, so commits do not wait for the UPDATE phase
      if (!committing && ((imm_pending && (update_start || !i_initiated)) ||
        (chan_pending && (update_start || !i_initiated) && chan_now != chan_ref)))
      begin
        committing <= 1'b1;
        imm_pending <= 1'b0;
        chan_pending <= 1'b0;
        q_rd <= 10'h000;
        rd_pipe <= 2'b00;
      end
      if (committing)
      begin
        rd_pipe <= {rd_pipe[0], q_rd < q_count};
        if (q_rd < q_count)
          q_rd <= q_rd + 10'h001;
        if (rd_pipe[0])
        begin
          o_live_we <= 1'b1;
          o_live_addr <= addr_rdata;
          o_live_data <= mem_rdata;
        end
        if (q_rd >= q_count && rd_pipe == 2'b00)
        begin
          committing <= 1'b0;
          q_count <= 10'h000;
          o_commit_done <= 1'b1;
        end
      end
    end
  end

  // ************************************************************
  // Value queries
  // ************************************************************
  // Held queries read shadow data after commit, i.e. post-commit value
  always @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      query_held <= 1'b0;
      query_addr <= {AW{1'b0}};
      q_wr_en <= 1'b0;
      o_query_valid <= 1'b0;
      o_query_data <= {DW{1'b0}};
      o_busy <= 1'b0;
    end
    else
    begin
      o_busy <= commit_req_any;
      o_query_valid <= 1'b0;
      q_wr_en <= 1'b0;
      if (i_query_req && !query_held)
      begin
        query_held <= 1'b1;
        query_addr <= i_query_addr;
      end
      if (query_held && !commit_req_any && !q_wr_en)
        q_wr_en <= 1'b1;
      if (q_wr_en)
      begin
        query_held <= 1'b0;
        o_query_valid <= 1'b1;
        o_query_data <= mem_rdata;
      end
    end
  end
endmodule
`default_nettype wire

// [shared/bus_update_map.vh]
// Constants of the buffered update sequencer
`ifndef BUS_UPDATE_MAP_VH
`define BUS_UPDATE_MAP_VH
`define BUS_WINDOW_RESET 10'h014
`define BUS_WINDOW_MIN 10'h001
`define BUS_WINDOW_MAX 10'h200
`define BUS_SLOT_NS 2000
`define BUS_CLK_NS 100
`define BUS_SLOT_CYCLES 20'h00014
`define BUS_DATA_W 16
`define BUS_ADDR_W 9
`endif

// [test/bus_host_model.sv]
// Host controller model issuing buffered writes and commits
`timescale 1ns/1ns
`default_nettype none
module bus_host_model (
  input wire logic i_clk_sys,
  input wire logic i_overflow_error,
  input wire logic i_commit_done,
  output logic o_write_req = 1'b0,
  output logic [8:0] o_write_addr = 9'h000,
  output logic [15:0] o_write_data = 16'h0000,
  output logic o_commit = 1'b0
);
  // ****************
  // Host commands
  // ****************
  task automatic commit;
    int n;
    @(negedge i_clk_sys) o_commit = 1'b1;
    @(negedge i_clk_sys) o_commit = 1'b0;
    for (n = 0; n < 400 && !i_commit_done; n++) @(negedge i_clk_sys);
  endtask
  // Write refused with an overflow error is retried once, after a commit
  task automatic send(input logic [15:0] d);
    logic ov;
    for (int k = 0; k < 2; k++)
    begin
      @(negedge i_clk_sys) o_write_req = 1'b1;
      o_write_data = d;
      o_write_addr = d[8:0];
      @(negedge i_clk_sys) o_write_req = 1'b0;
      ov = i_overflow_error;
      o_write_data = ~d;
      @(negedge i_clk_sys) ov = ov | i_overflow_error;
      if (!ov)
        k = 2;
      else
        commit();
    end
  endtask
endmodule
`default_nettype wire

// [test/bus_seq_assertions.sv]
// Port assertions of the buffered update sequencer
`timescale 1ns/1ns
`default_nettype none
module bus_seq_chk (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_initiated,
  input wire logic i_write_req,
  input wire logic i_query_req,
  input wire logic i_commit_now_request,
  input wire logic i_commit_on_input_change,
  input wire logic i_window_write,
  input wire logic [9:0] i_update_window_count,
  input wire logic o_write_ack,
  input wire logic o_window_refused,
  input wire logic o_busy,
  input wire logic o_query_valid,
  input wire logic o_phase_update,
  input wire logic [9:0] o_window
);
  // ****************
  // Phase length count and properties
  // ****************
  logic [13:0] upd_len;
  always_ff @(posedge i_clk_sys or posedge i_reset)
    if (i_reset)
      upd_len <= 14'h0000;
    else
      upd_len <= o_phase_update ? upd_len + 14'h0001 : 14'h0000;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  property p_win_reset; $fell(i_reset) |-> o_window == 10'h014; endproperty
  a_win_reset: assert property (p_win_reset) else $error("window not default");
  property p_win_refuse; i_window_write && i_initiated |=> o_window_refused && $stable(o_window);
  endproperty
  a_win_refuse: assert property (p_win_refuse) else $error("window taken");
  property p_win_set; i_window_write && !i_initiated && i_update_window_count inside {[1:512]}
    |=> o_window == $past(i_update_window_count); endproperty
  a_win_set: assert property (p_win_set) else $error("window not set");
  property p_busy_block; o_busy && i_write_req |=> !o_write_ack; endproperty
  a_busy_block: assert property (p_busy_block) else $error("write taken while busy");
  property p_imm_busy; i_commit_now_request && !o_busy |-> ##2 o_busy; endproperty
  a_imm_busy: assert property (p_imm_busy) else $error("commit not pending");
  property p_chan_busy; i_commit_on_input_change && !o_busy |-> ##2 o_busy; endproperty
  a_chan_busy: assert property (p_chan_busy) else $error("input wait not busy");
  property p_query_hold; o_busy && i_query_req |=> !o_query_valid; endproperty
  a_query_hold: assert property (p_query_hold) else $error("query not held");
  property p_upd_len; $fell(o_phase_update) && i_initiated |-> upd_len == o_window * 14'h0014;
  endproperty
  a_upd_len: assert property (p_upd_len) else $error("update length wrong");
endmodule
bind bus_update_seq bus_seq_chk chk_u (.*);
`default_nettype wire

// [test/test_buffered_update_sequencer.sv]
// Testbench of the buffered update sequencer
`timescale 1ns/1ns
`default_nettype none
module test_buffered_update_sequencer;
  logic i_clk_sys = 1'b0, i_reset = 1'b1, i_initiated = 1'b0, i_scan_trigger = 1'b0;
  logic i_query_req = 1'b0, i_commit_on_input_change = 1'b0, i_window_write = 1'b0;
  logic [2:0] i_input_select = 3'h3;
  logic [7:0] i_digital_in = 8'h00;
  logic [9:0] i_update_window_count = 10'h000;
  logic [8:0] i_query_addr = 9'h000;
  wire logic i_write_req, i_commit_now_request, o_write_ack, o_overflow_error, o_window_refused;
  wire logic o_busy, o_query_valid, o_live_we, o_commit_done, o_phase_input, o_phase_update;
  wire logic [8:0] i_write_addr, o_live_addr;
  wire logic [15:0] i_write_data, o_query_data, o_live_data;
  wire logic [9:0] o_window;
  int mismatches = 0, n_compared = 0, acks = 0, ovfs = 0, qvs = 0, n;
  logic [15:0] lq[$];
  logic [21:0] rows[6] = '{{1'b0, 10'h001, 1'b0, 10'h001}, {1'b0, 10'h200, 1'b0, 10'h200},
    {1'b0, 10'h000, 1'b1, 10'h200}, {1'b0, 10'h201, 1'b1, 10'h200},
    {1'b1, 10'h003, 1'b1, 10'h200}, {1'b0, 10'h002, 1'b0, 10'h002}};
  bus_update_seq dut_u (.*);
  bus_host_model host_u (.i_clk_sys(i_clk_sys), .i_overflow_error(o_overflow_error),
    .i_commit_done(o_commit_done), .o_write_req(i_write_req), .o_write_addr(i_write_addr),
    .o_write_data(i_write_data), .o_commit(i_commit_now_request));
  initial
    forever #50 i_clk_sys = ~i_clk_sys;
  always @(negedge i_clk_sys)
  begin
    if (o_live_we)
      lq.push_back(o_live_data);
    acks += o_write_ack;
    ovfs += o_overflow_error;
    qvs += o_query_valid;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test;
    if (mismatches == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(negedge i_clk_sys);
    i_reset = 1'b0;
    chk("window", 16'h0014, {6'h00, o_window});
    foreach (rows[i])
    begin
      @(negedge i_clk_sys) {i_initiated, i_update_window_count} = rows[i][21:11];
      i_window_write = 1'b1;
      @(negedge i_clk_sys) i_window_write = 1'b0;
      chk("refused", {15'h0000, rows[i][10]}, {15'h0000, o_window_refused});
      chk("window", {6'h00, rows[i][9:0]}, {6'h00, o_window});
    end
    host_u.send(16'h0A0A);
    host_u.send(16'h0B0B);
    chk("early live writes", 16'h0000, 16'(lq.size()));
    host_u.send(16'h0C0C);
    host_u.commit();
    chk("overflows", 16'h0001, 16'(ovfs));
    chk("acks", 16'h0003, 16'(acks));
    chk("live order", 16'h0A0A, lq[0]);
    chk("live order", 16'h0B0B, lq[1]);
    chk("live order", 16'h0C0C, lq[2]);
    host_u.send(16'h1234);
    @(negedge i_clk_sys) i_commit_on_input_change = 1'b1;
    @(negedge i_clk_sys) i_commit_on_input_change = 1'b0;
    repeat (30) @(negedge i_clk_sys);
    chk("waiting busy", 16'h0001, {15'h0000, o_busy});
    host_u.send(16'h5555);
    chk("acks while waiting", 16'h0004, 16'(acks));
    @(negedge i_clk_sys) i_query_req = 1'b1;
    @(negedge i_clk_sys) i_query_req = 1'b0;
    chk("live before change", 16'h0003, 16'(lq.size()));
    i_digital_in = 8'h08;
    for (n = 0; n < 400 && o_commit_done !== 1'b1; n++) @(negedge i_clk_sys);
    chk("commit done", 16'h0001, {15'h0000, o_commit_done});
    repeat (5) @(negedge i_clk_sys);
    chk("live after change", 16'h1234, lq[$]);
    chk("live addr", 16'h0034, {7'h00, o_live_addr});
    chk("query data", 16'h1234, o_query_data);
    chk("held query", 16'h0001, 16'(qvs));
    i_initiated = 1'b1;
    repeat (2)
    begin
      i_scan_trigger = 1'b1;
      for (n = 0; n < 2000 && o_phase_input !== 1'b1; n++) @(negedge i_clk_sys);
      chk("input start", 16'h0001, {15'h0000, o_phase_input});
      for (n = 0; n < 2000 && o_phase_update !== 1'b1; n++) @(negedge i_clk_sys);
      i_scan_trigger = 1'b0;
      chk("update start", 16'h0001, {15'h0000, o_phase_update});
      if (o_phase_update !== 1'b1)
        stop_test();
      for (n = 0; n < 2000 && o_phase_update === 1'b1; n++) @(negedge i_clk_sys);
      chk("update length", 16'h0028, 16'(n));
    end
    host_u.send(16'h7777);
    chk("acks outside phases", 16'h0004, 16'(acks));
    stop_test();
  end
endmodule
`default_nettype wire
